/* File: bench/tpd_enforcer_sva.sv */
// Checker for the pulse density enforcer, seen from its top-level ports.
// Assumes a single clock domain and the register master of the bench.
`timescale 1ns/100ps
module tpd_enforcer_sva import tpd_pkg::*; #(
    parameter int MAX_N = MAX_ONES_N
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Mode and register port
    input wire logic e1_not_t1_select_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    // Stream and interrupt
    input wire logic pcm_data_i,
    input wire logic pcm_valid_i,
    input wire logic pcm_data_o,
    input wire logic pcm_valid_o,
    input wire logic irq_out_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    logic rd_hit;
    assign rd_hit = rd_i && (addr_i == CTRL_STATUS_OFF);
    property p_e1; e1_not_t1_select_i && $past(e1_not_t1_select_i) && rd_i
        |=> rd_data_o == 8'h00; endproperty
    a_e1: assert property (p_e1) else $error("register not held");
    property p_rd0; !rd_hit |=> rd_data_o == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("read data not idle");
    // Stuffing only ever turns a zero into a one
    property p_one; pcm_valid_i && pcm_data_i |=> pcm_data_o; endproperty
    a_one: assert property (p_one) else $error("one altered");
    property p_hold; !pcm_valid_i |=> $stable(pcm_data_o); endproperty
    a_hold: assert property (p_hold) else $error("output bit moved");
    property p_fall; $fell(irq_out_n_o)
        |-> $past(pcm_valid_i, 2) || $past(wr_i, 2); endproperty
    a_fall: assert property (p_fall) else $error("irq without cause");
    property p_zr; rd_data_o[ZERO_RUN_FLAG_BIT]
        && rd_data_o[ZERO_RUN_IRQ_ENABLE_BIT] |-> !irq_out_n_o; endproperty
    a_zr: assert property (p_zr) else $error("zero run irq missing");
    property p_fl; rd_data_o[FILL_EVENT_FLAG_BIT]
        && rd_data_o[FILL_IRQ_ENABLE_BIT] |-> !irq_out_n_o; endproperty
    a_fl: assert property (p_fl) else $error("fill irq missing");
    property p_dc; rd_data_o[2] && rd_data_o[0] && !rd_data_o[7]
        |-> !irq_out_n_o; endproperty
    a_dc: assert property (p_dc) else $error("change irq missing");
    property p_idle; $past(rd_hit) && !(rd_data_o[3] && rd_data_o[1])
        && !(rd_data_o[5] && rd_data_o[7])
        && !(rd_data_o[2] && rd_data_o[0] && !rd_data_o[7])
        |-> irq_out_n_o; endproperty
    a_idle: assert property (p_idle) else $error("irq stuck low");
    property p_fill; rd_data_o[FILL_ENABLE_BIT]
        |-> rd_data_o[4:2] == 3'b000; endproperty
    a_fill: assert property (p_fill) else $error("flags set");
    property p_vld; pcm_valid_o == $past(pcm_valid_i); endproperty
    a_vld: assert property (p_vld) else $error("valid not delayed");
    c_rd: cover property (rd_hit);
    c_irq: cover property (!irq_out_n_o);
    c_zero: cover property (pcm_valid_i && !pcm_data_i ##1 pcm_data_o);
endmodule
bind tpd_enforcer tpd_enforcer_sva #(.MAX_N(MAX_N)) tpd_enforcer_sva_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .e1_not_t1_select_i(e1_not_t1_select_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .pcm_data_i(pcm_data_i), .pcm_valid_i(pcm_valid_i),
    .pcm_data_o(pcm_data_o), .pcm_valid_o(pcm_valid_o),
    .irq_out_n_o(irq_out_n_o));

/* File: bench/tpd_enforcer_tb.sv */
// Self-checking bench for the pulse density enforcer.
// Assumes the stream model and the checker bound to the design.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); \
    end end
module tpd_enforcer_tb;
    import tpd_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, e1_i = 1'b0, wr_i = 1'b0;
    logic rd_i = 1'b0, go = 1'b0, pdi, pvi, pdo, pvo, irq_n, busy;
    logic [7:0] addr_i = 8'h00, wd = 8'h00, rdd, v, n1 = 8'h00, n0 = 8'h00;
    int n_errors = 0, comparisons = 0, cyc = 0, ones = 0, c;
    tpd_src tpd_src_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go),
        .ones_i(n1), .zeros_i(n0), .busy_o(busy), .pcm_data_o(pdi),
        .pcm_valid_o(pvi));
    tpd_enforcer tpd_enforcer_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .e1_not_t1_select_i(e1_i), .addr_i(addr_i), .wr_data_i(wd),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdd), .pcm_data_i(pdi),
        .pcm_valid_i(pvi), .pcm_data_o(pdo), .pcm_valid_o(pvo),
        .irq_out_n_o(irq_n));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (pvo === 1'b1 && pdo === 1'b1) ones++;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Bus and stream tasks
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a; wd <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdd;
        repeat (2) @(negedge clk_i);
    endtask
    task send(input logic [7:0] o, input logic [7:0] z);
        @(posedge clk_i);
        n1 <= o; n0 <= z; go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (100) begin
            @(negedge clk_i);
            if (busy !== 1'b1) break;
        end
        repeat (3) @(negedge clk_i);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset();
        rd(CTRL_STATUS_OFF, v); `CHK("reset value", CTRL_STATUS_RST, v)
        rd(8'h68, v); `CHK("unmapped read", 8'h00, v)
        `CHK("irq idle", 1'b1, irq_n)
    endtask
    task t_e1();
        wr(CTRL_STATUS_OFF, 8'h03);
        @(posedge clk_i) e1_i <= 1'b1;
        wr(CTRL_STATUS_OFF, 8'hff);
        rd(CTRL_STATUS_OFF, v); `CHK("e1 hold", 8'h00, v)
        @(posedge clk_i) e1_i <= 1'b0;
        rd(CTRL_STATUS_OFF, v); `CHK("e1 after", 8'h00, v)
    endtask
    // Enable 8'h01 or 8'h02: the zero run latches either way
    task t_pass(input logic [7:0] en);
        wr(CTRL_STATUS_OFF, en);
        c = ones;
        send(8'h08, 8'h10);
        `CHK("pass ones", 8, ones - c)
        `CHK("irq on run", 1'b0, irq_n)
        rd(CTRL_STATUS_OFF, v); `CHK("run flags", 8'h1c | en, v)
        send(8'h01, 8'h00);
        `CHK("irq on end", ~en[0], irq_n)
        rd(CTRL_STATUS_OFF, v); `CHK("end flags", 8'h04 | en, v)
        rd(CTRL_STATUS_OFF, v); `CHK("flags clear", en, v)
        `CHK("irq clear", 1'b1, irq_n)
    endtask
    task t_stuff();
        wr(CTRL_STATUS_OFF, 8'hff);
        c = ones;
        send(8'h08, 8'h10);
        `CHK("stuffed ones", 9, ones - c)
        `CHK("irq on fill", 1'b0, irq_n)
        wr(8'h6a, 8'h00);
        rd(CTRL_STATUS_OFF, v); `CHK("fill flags", 8'he3, v)
        `CHK("irq cleared", 1'b1, irq_n)
        rd(CTRL_STATUS_OFF, v); `CHK("fill clear", 8'hc3, v)
        wr(CTRL_STATUS_OFF, 8'h00);
    endtask
    task end_of_test();
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_e1();
        t_pass(8'h01);
        t_pass(8'h02);
        t_stuff();
        end_of_test();
    end
endmodule

/* File: bench/tpd_src.sv */
// Upstream transmit stream model: a run of ones, then a run of zeros.
// Assumes one bit per cycle; the data line toggles while idle.
`timescale 1ns/100ps
module tpd_src (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Command
    input wire logic go_i,
    input wire logic [7:0] ones_i,
    input wire logic [7:0] zeros_i,
    output logic busy_o,
    // Stream
    output logic pcm_data_o,
    output logic pcm_valid_o
);
    logic [7:0] n1_q;
    logic [7:0] n0_q;
    assign busy_o = (n1_q != 8'h00) || (n0_q != 8'h00);
    // Idle toggling keeps a stale bit from passing for a real one
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            n1_q <= 8'h00;
            n0_q <= 8'h00;
            pcm_valid_o <= 1'b0;
            pcm_data_o <= 1'b0;
        end else if (busy_o && !go_i) begin
            pcm_valid_o <= 1'b1;
            pcm_data_o <= (n1_q != 8'h00);
            if (n1_q != 8'h00) n1_q <= n1_q - 8'h01;
            else n0_q <= n0_q - 8'h01;
        end else begin
            pcm_valid_o <= 1'b0;
            pcm_data_o <= ~pcm_data_o;
            if (go_i) begin
                n1_q <= ones_i;
                n0_q <= zeros_i;
            end
        end
    end
endmodule

/* File: rtl/tpd_enforcer.sv */
// T1 transmit pulse density enforcer with its control/status register.
// Assumes one PCM bit per cycle in which pcm_valid_i is high and a
// register master that never issues read and write together.
//
// Contract
// - E1 select high holds the control/status register at reset.
// - Fill enable set: insert a one wherever a density violation appears.
// - Fill clear: pass data unchanged, report via density-change flag.
// - Fill-event flag set per inserted bit, cleared by a register read.
// - Fill interrupt enable routes stuff events to interrupt; read clears.
// - Live violation bit follows the present violation, even one bit long.
// - Live violation bit held zero while fill is enabled.
// - Density-change flag set on each violation edge, cleared on read.
// - Zero-run flag set on sixteen consecutive zeros, cleared on read.
// - Density-change and zero-run flags latch regardless of interrupt enables.
// - Fill enable forces density-change and zero-run flags to zero.
// - Zero-run interrupt enable gates zero-run events onto interrupt.
// - Density-change enable with fill interrupt off: both edges interrupt.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module tpd_enforcer #(
    parameter int MAX_N = tpd_pkg::MAX_ONES_N
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Global mode
    input wire logic e1_not_t1_select_i,
    // Register port
    input wire logic [tpd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [tpd_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [tpd_pkg::DATA_W-1:0] rd_data_o,
    // Transmit PCM in
    input wire logic pcm_data_i,
    input wire logic pcm_valid_i,
    // Transmit PCM out
    output logic pcm_data_o,
    output logic pcm_valid_o,
    // Interrupt
    output logic irq_out_n_o
);
    import tpd_pkg::*;

    localparam int HIST_W = WINDOW_STEP * (MAX_N + 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // True when a window would hold fewer than n ones after the shift
    // One spare bit keeps the sum from wrapping
    function automatic logic win_short(input logic [CNT_W-1:0] cnt,
                                       input logic out_bit,
                                       input logic in_bit,
                                       input int unsigned n);
        logic [CNT_W:0] next;
        next = {1'b0, cnt} - {{CNT_W{1'b0}}, out_bit}
             + {{CNT_W{1'b0}}, in_bit};
        return next < (CNT_W+1)'(n);
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic fill_irq_enable_q;
    logic fill_enable_q;
    logic fill_event_flag_q;
    logic violation_live_q;
    logic zero_run_flag_q;
    logic density_change_flag_q;
    logic zero_run_irq_enable_q;
    logic density_change_irq_enable_q;
    logic [DATA_W-1:0] rd_data_q;
    logic irq_n_q;

    logic reg_hit;
    logic wr_hit;
    logic rd_clr;
    logic [DATA_W-1:0] reg_view;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // One address only; every other one reads as zero
    assign reg_hit = (addr_i == CTRL_STATUS_OFF);
    assign wr_hit = wr_i && reg_hit;
    assign rd_clr = rd_i && reg_hit;

    // ------------------------------------------------------------
    // Density tracking state
    // ------------------------------------------------------------
    logic [HIST_W-1:0] hist_q;
    logic [CNT_W-1:0] cnt_q [1:MAX_N];
    logic [ZRUN_W-1:0] zrun_q;
    logic pcm_data_q;
    logic pcm_valid_q;

    logic viol_now;
    logic stuff_now;
    logic out_bit;
    logic zero_hit;
    logic win_viol;
    logic zrun_viol;
    logic fill_arm;
    logic flag_clr;

    // Check every window for the incoming bit
    always_comb begin
        win_viol = 1'b0;
        for (int n = 1; n <= MAX_N; n++) begin
            if (win_short(cnt_q[n], hist_q[WINDOW_STEP*(n+1)-1],
                          pcm_data_i, n)) begin
                win_viol = 1'b1;
            end
        end
    end

    // A sixteenth zero in a row breaks the rule on its own
    assign zrun_viol = !pcm_data_i
        && zrun_q >= ZRUN_W'(ZERO_RUN_LIMIT - 1);
    assign viol_now = win_viol || zrun_viol;

    // A one can only fill a violation caused by a zero
    assign stuff_now = fill_enable_q && !pcm_data_i && viol_now;
    assign out_bit = pcm_data_i | stuff_now;
    // Zero run follows output bits, so a stuffed one restarts it
    assign zero_hit = !out_bit && zrun_q >= ZRUN_W'(ZERO_RUN_LIMIT - 1);

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    // History starts as all ones so no false violation after reset
    // A deep shift register buys an exact check of every window
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hist_q <= '1;
        end else if (pcm_valid_i) begin
            hist_q <= {hist_q[HIST_W-2:0], out_bit};
        end
    end

    for (genvar g = 1; g <= MAX_N; g++) begin : g_win
        localparam logic [CNT_W-1:0] FULL = CNT_W'(WINDOW_STEP * (g + 1));
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cnt_q[g] <= FULL;
            end else if (pcm_valid_i) begin
                cnt_q[g] <= cnt_q[g]
                          - {{(CNT_W-1){1'b0}},
                             hist_q[WINDOW_STEP*(g+1)-1]}
                          + {{(CNT_W-1){1'b0}}, out_bit};
            end
        end
    end

    // Zero run saturates at the limit so long runs stay flagged
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zrun_q <= '0;
        end else if (pcm_valid_i) begin
            if (out_bit) begin
                zrun_q <= '0;
            end else if (zrun_q < ZRUN_W'(ZERO_RUN_LIMIT)) begin
                zrun_q <= zrun_q + ZRUN_W'(1);
            end
        end
    end

    // Output bit holds between strobes
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pcm_data_q <= 1'b0;
        end else if (pcm_valid_i) begin
            pcm_data_q <= out_bit;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pcm_valid_q <= 1'b0;
        end else begin
            pcm_valid_q <= pcm_valid_i;
        end
    end

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    // Writes are refused while E1 is selected
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_irq_enable_q <= CTRL_STATUS_RST[FILL_IRQ_ENABLE_BIT];
        end else if (e1_not_t1_select_i) begin
            fill_irq_enable_q <= CTRL_STATUS_RST[FILL_IRQ_ENABLE_BIT];
        end else if (wr_hit) begin
            fill_irq_enable_q <= wr_data_i[FILL_IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_enable_q <= CTRL_STATUS_RST[FILL_ENABLE_BIT];
        end else if (e1_not_t1_select_i) begin
            fill_enable_q <= CTRL_STATUS_RST[FILL_ENABLE_BIT];
        end else if (wr_hit) begin
            fill_enable_q <= wr_data_i[FILL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zero_run_irq_enable_q <= CTRL_STATUS_RST[ZERO_RUN_IRQ_ENABLE_BIT];
        end else if (e1_not_t1_select_i) begin
            zero_run_irq_enable_q <= CTRL_STATUS_RST[ZERO_RUN_IRQ_ENABLE_BIT];
        end else if (wr_hit) begin
            zero_run_irq_enable_q <= wr_data_i[ZERO_RUN_IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            density_change_irq_enable_q <=
                CTRL_STATUS_RST[DENSITY_CHANGE_IRQ_ENABLE_BIT];
        end else if (e1_not_t1_select_i) begin
            density_change_irq_enable_q <=
                CTRL_STATUS_RST[DENSITY_CHANGE_IRQ_ENABLE_BIT];
        end else if (wr_hit) begin
            density_change_irq_enable_q <=
                wr_data_i[DENSITY_CHANGE_IRQ_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Status and event flags
    // ------------------------------------------------------------
    // Turning fill on clears the flags at the write's own edge, so no
    // read shows fill set beside stale density flags
    assign fill_arm = wr_hit && wr_data_i[FILL_ENABLE_BIT];
    assign flag_clr = e1_not_t1_select_i || fill_enable_q || fill_arm;

    // Live violation only meaningful in pass mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            violation_live_q <= 1'b0;
        end else if (flag_clr) begin
            violation_live_q <= 1'b0;
        end else if (pcm_valid_i) begin
            violation_live_q <= viol_now;
        end
    end

    // Set beats the clear of a read in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_event_flag_q <= 1'b0;
        end else if (e1_not_t1_select_i) begin
            fill_event_flag_q <= 1'b0;
        end else if (pcm_valid_i && stuff_now) begin
            fill_event_flag_q <= 1'b1;
        end else if (rd_clr) begin
            fill_event_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            density_change_flag_q <= 1'b0;
        end else if (flag_clr) begin
            density_change_flag_q <= 1'b0;
        end else if (pcm_valid_i && viol_now != violation_live_q) begin
            density_change_flag_q <= 1'b1;
        end else if (rd_clr) begin
            density_change_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zero_run_flag_q <= 1'b0;
        end else if (flag_clr) begin
            zero_run_flag_q <= 1'b0;
        end else if (pcm_valid_i && zero_hit) begin
            zero_run_flag_q <= 1'b1;
        end else if (rd_clr) begin
            zero_run_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        reg_view = '0;
        reg_view[FILL_IRQ_ENABLE_BIT] = fill_irq_enable_q;
        reg_view[FILL_ENABLE_BIT] = fill_enable_q;
        reg_view[FILL_EVENT_FLAG_BIT] = fill_event_flag_q;
        reg_view[VIOLATION_LIVE_BIT] = violation_live_q;
        reg_view[ZERO_RUN_FLAG_BIT] = zero_run_flag_q;
        reg_view[DENSITY_CHANGE_FLAG_BIT] = density_change_flag_q;
        reg_view[ZERO_RUN_IRQ_ENABLE_BIT] = zero_run_irq_enable_q;
        reg_view[DENSITY_CHANGE_IRQ_ENABLE_BIT] = density_change_irq_enable_q;
    end

    // Unmapped reads answer zero; data stands for one cycle only
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_q <= '0;
        end else if (rd_i) begin
            rd_data_q <= reg_hit ? reg_view : '0;
        end else begin
            rd_data_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Registered, so it trails the flags by one cycle
    // Change events stay off the pin while fill interrupts are on
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= !((fill_event_flag_q && fill_irq_enable_q)
                || (zero_run_flag_q && zero_run_irq_enable_q)
                || (density_change_flag_q && density_change_irq_enable_q
                    && !fill_irq_enable_q));
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output leaves straight from a flop
    assign rd_data_o = rd_data_q;
    assign pcm_data_o = pcm_data_q;
    assign pcm_valid_o = pcm_valid_q;
    assign irq_out_n_o = irq_n_q;

endmodule

/* File: rtl/tpd_pkg.sv */
// Constants for the T1 transmit pulse density enforcer.
// Assumes a byte-wide register port and a bit-serial PCM stream.
package tpd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_STATUS_OFF = 8'h69;
    localparam logic [DATA_W-1:0] CTRL_STATUS_RST = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FILL_IRQ_ENABLE_BIT = 7;
    localparam int FILL_ENABLE_BIT = 6;
    localparam int FILL_EVENT_FLAG_BIT = 5;
    localparam int VIOLATION_LIVE_BIT = 4;
    localparam int ZERO_RUN_FLAG_BIT = 3;
    localparam int DENSITY_CHANGE_FLAG_BIT = 2;
    localparam int ZERO_RUN_IRQ_ENABLE_BIT = 1;
    localparam int DENSITY_CHANGE_IRQ_ENABLE_BIT = 0;

    // ------------------------------------------------------------
    // Density rule
    // ------------------------------------------------------------
    localparam int ZERO_RUN_LIMIT = 16;
    localparam int MAX_ONES_N = 23;
    localparam int WINDOW_STEP = 8;
    localparam int CNT_W = 8;
    localparam int ZRUN_W = 5;

endpackage
